/* hdl/reference_select_code_consts.svh */
// Constants of the reference selection control: offsets, fields, reset values.
`ifndef REFERENCE_SELECT_CODE_CONSTS_SVH
`define REFERENCE_SELECT_CODE_CONSTS_SVH
`define REG_ADDR_W 8
`define OFS_SELECT 8'h08
`define OFS_ENABLE 8'h0A
`define OFS_STATUS 8'h40
`define OFS_HISTORY 8'h41
`define SEL_CODE_LSB 4
`define SEL_CODE_MSB 6
`define EXCL0_BIT 4
`define EXCL1_BIT 5
`define RST_SEL_CODE 3'h0
`define RST_EXCL 1'h0
`define HIST_DEPTH 8
`endif

/* hdl/reference_select_code_pkg.sv */
// Types shared by the reference selection control.
package reference_select_code_pkg;
    typedef enum logic [2:0] {
        SEL_AUTO = 3'h0,
        SEL_PIN = 3'h1,
        SEL_RSV2 = 3'h2,
        SEL_RSV3 = 3'h3,
        SEL_FORCE0 = 3'h4,
        SEL_FORCE1 = 3'h5,
        SEL_BAD6 = 3'h6,
        SEL_BAD7 = 3'h7
    } sel_code_t;
    typedef logic [7:0] reg_word_t;
endpackage

/* hdl/switch_history_mem.sv */
// Small memory that logs recent reference switch events, registered read.
`timescale 1ns/10ps
module switch_history_mem #(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock.
    input wire logic i_sys_clk,
    // Write side.
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    // Read side.
    input wire logic [AW-1:0] i_rd_addr,
    output logic [7:0] o_rd_data
);
    logic [7:0] mem [DEPTH];

    // Storage has no reset; software reads only entries it knows were written.
    // A write to the word being fetched wins, so a fresh entry is never returned stale.
    always_ff @(posedge i_sys_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        if (i_wr_en && i_wr_addr == i_rd_addr) begin
            o_rd_data <= i_wr_data;
        end else begin
            o_rd_data <= mem[i_rd_addr];
        end
    end
endmodule

/* hdl/reference_select_code_ctrl.sv */
// Top of the PLL input reference selection control.
`timescale 1ns/10ps
`include "reference_select_code_consts.svh"
module reference_select_code_ctrl #(
    parameter int HIST_DEPTH = `HIST_DEPTH
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register port.
    input wire logic [`REG_ADDR_W-1:0] i_addr,
    input wire reference_select_code_pkg::reg_word_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output reference_select_code_pkg::reg_word_t o_rdata,
    // Reference condition and manual select pin.
    input wire logic i_ref0_lost,
    input wire logic i_ref1_lost,
    input wire logic i_sel_pin,
    // Selection result.
    output logic o_ref_sel,
    output logic o_holdover,
    output logic o_bad_code
);
    import reference_select_code_pkg::*;

    localparam int HAW = $clog2(HIST_DEPTH);

    // ****************************************
    // Configuration registers
    // ****************************************
    sel_code_t sel_code_r;
    logic excl0_r;
    logic excl1_r;
    logic [7:0] hist_rdata;
    logic [HAW-1:0] hist_wptr_r;
    logic [HAW-1:0] hist_rptr_r;
    logic [HAW-1:0] hist_rptr_nxt;
    reg_word_t rdata_nxt;

    // Selection code written by software; held until rewritten.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sel_code_r <= sel_code_t'(`RST_SEL_CODE);
        end else if (i_wr && i_addr == `OFS_SELECT) begin
            sel_code_r <= sel_code_t'(i_wdata[`SEL_CODE_MSB:`SEL_CODE_LSB]);
        end
    end

    // Exclusion bits reset to zero so both inputs start as candidates.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            excl0_r <= `RST_EXCL;
            excl1_r <= `RST_EXCL;
        end else if (i_wr && i_addr == `OFS_ENABLE) begin
            excl0_r <= i_wdata[`EXCL0_BIT];
            excl1_r <= i_wdata[`EXCL1_BIT];
        end
    end

    // ****************************************
    // Reference choice
    // ****************************************
    logic ref_sel_nxt;
    logic holdover_nxt;
    logic cand0;
    logic cand1;

    // An input counts for automatic choice only while healthy and not excluded.
    // exclude ref 0
    assign cand0 = !i_ref0_lost && !excl0_r;
    assign cand1 = !i_ref1_lost && !excl1_r;

    // Next selection; reserved codes keep the present choice rather than
    // jumping to an arbitrary input, which would upset the loop.
    always_comb begin
        ref_sel_nxt = o_ref_sel;
        holdover_nxt = 1'b0;
        case (sel_code_r)
            SEL_AUTO: begin
                if (o_ref_sel ? cand1 : cand0) begin
                    ref_sel_nxt = o_ref_sel;
                end else if (o_ref_sel ? cand0 : cand1) begin
                    ref_sel_nxt = !o_ref_sel;
                end else begin
                    holdover_nxt = 1'b1;
                end
            end
            SEL_PIN: ref_sel_nxt = i_sel_pin;
            SEL_FORCE0: ref_sel_nxt = 1'b0;
            SEL_FORCE1: ref_sel_nxt = 1'b1;
            default: ref_sel_nxt = o_ref_sel;
        endcase
    end

    // Selection and holdover flags are registered outputs.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_ref_sel <= 1'b0;
            o_holdover <= 1'b0;
        end else begin
            o_ref_sel <= ref_sel_nxt;
            o_holdover <= holdover_nxt;
        end
    end

    // Flag an illegal code so firmware mistakes are visible.
    // flag forbidden codes
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_bad_code <= 1'b0;
        end else begin
            o_bad_code <= sel_code_r inside {SEL_RSV2, SEL_RSV3, SEL_BAD6, SEL_BAD7};
        end
    end

    // ****************************************
    // Switch history
    // ****************************************
    // Each change of selection logs the new input and the mode that caused it.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hist_wptr_r <= '0;
        end else if (ref_sel_nxt != o_ref_sel) begin
            hist_wptr_r <= hist_wptr_r + 1'b1;
        end
    end

    // Read pointer advances on every read of the history register.
    always_comb begin
        hist_rptr_nxt = hist_rptr_r;
        if (i_rd && i_addr == `OFS_HISTORY) begin
            hist_rptr_nxt = hist_rptr_r + 1'b1;
        end
    end

    // Pointer register; the memory fetches at the next pointer one cycle ahead.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hist_rptr_r <= '0;
        end else begin
            hist_rptr_r <= hist_rptr_nxt;
        end
    end

    switch_history_mem #(
        .DEPTH(HIST_DEPTH),
        .AW(HAW)
    ) u_hist (
        .i_sys_clk(i_sys_clk),
        .i_wr_en(ref_sel_nxt != o_ref_sel),
        .i_wr_addr(hist_wptr_r),
        .i_wr_data({4'h0, sel_code_r, ref_sel_nxt}),
        .i_rd_addr(hist_rptr_nxt),
        .o_rd_data(hist_rdata)
    );

    // ****************************************
    // Register read port
    // ****************************************
    // Read data mux; unmapped addresses and idle cycles return zero.
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `OFS_SELECT: rdata_nxt[`SEL_CODE_MSB:`SEL_CODE_LSB] = sel_code_r;
                `OFS_ENABLE: begin
                    rdata_nxt[`EXCL0_BIT] = excl0_r;
                    rdata_nxt[`EXCL1_BIT] = excl1_r;
                end
                `OFS_STATUS: rdata_nxt = {5'h00, o_bad_code, o_holdover, o_ref_sel};
                // Prefetched word, so the read port stays a single register.
                `OFS_HISTORY: rdata_nxt = hist_rdata;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data register; the word stands for the one cycle after the strobe.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_force0_set;
        sel_code_r == SEL_FORCE0;
    endsequence

    a_force_ref_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_force0_set ##1 s_force0_set |-> !o_ref_sel)
        else $error("forced reference 0 not selected");

    a_force_ref_one: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sel_code_r == SEL_FORCE1 ##1 sel_code_r == SEL_FORCE1 |-> o_ref_sel)
        else $error("forced reference 1 not selected");

    a_pin_mode_follow: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sel_code_r == SEL_PIN |=> o_ref_sel == $past(i_sel_pin))
        else $error("selection did not follow pin");

    a_auto_no_excl0: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sel_code_r == SEL_AUTO && excl0_r && o_ref_sel |=> o_ref_sel)
        else $error("switched to excluded reference 0");

    a_auto_no_excl1: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sel_code_r == SEL_AUTO && excl1_r && !o_ref_sel |=> !o_ref_sel)
        else $error("switched to excluded reference 1");

    a_auto_switch_ok: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sel_code_r == SEL_AUTO && !o_ref_sel && i_ref0_lost && cand1 |=> o_ref_sel)
        else $error("automatic switchover to good reference missed");

    a_bad_code_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sel_code_r == SEL_BAD6 |=> o_bad_code)
        else $error("forbidden code not flagged");
endmodule

/* testbench/ref_clock_sources.sv */
// Model of the two input reference clock sources and their loss reports.
`timescale 1ns/10ps
module ref_clock_sources #(
    parameter int DLY = 2
) (
    // Clock.
    input wire logic i_sys_clk,
    // Fault commands from the bench.
    input wire logic i_fail0,
    input wire logic i_fail1,
    // Loss reports towards the selection control.
    output logic o_ref0_lost,
    output logic o_ref1_lost
);
    logic [DLY-1:0] pipe0_r = '0;
    logic [DLY-1:0] pipe1_r = '0;
    // A monitor needs several missing edges to call a loss, so reports lag by DLY cycles.
    always @(posedge i_sys_clk) begin
        pipe0_r <= (pipe0_r << 1) | DLY'(i_fail0);
        pipe1_r <= (pipe1_r << 1) | DLY'(i_fail1);
    end
    assign o_ref0_lost = pipe0_r[DLY-1];
    assign o_ref1_lost = pipe1_r[DLY-1];
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the reference selection control.
`timescale 1ns/10ps
`include "reference_select_code_consts.svh"
module tb_top;
    import reference_select_code_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    reg_word_t i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    reg_word_t o_rdata;
    logic fail0 = 1'b0;
    logic fail1 = 1'b0;
    logic i_ref0_lost;
    logic i_ref1_lost;
    logic i_sel_pin = 1'b0;
    logic o_ref_sel;
    logic o_holdover;
    logic o_bad_code;
    int err_count = 0;
    int check_count = 0;
    sel_code_t bad_list [4] = '{SEL_RSV2, SEL_RSV3, SEL_BAD6, SEL_BAD7};

    reference_select_code_ctrl reference_select_code_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ref0_lost(i_ref0_lost), .i_ref1_lost(i_ref1_lost), .i_sel_pin(i_sel_pin),
        .o_ref_sel(o_ref_sel), .o_holdover(o_holdover), .o_bad_code(o_bad_code));
    ref_clock_sources #(.DLY(2)) ref_clock_sources_i (.i_sys_clk(i_sys_clk),
        .i_fail0(fail0), .i_fail1(fail1),
        .o_ref0_lost(i_ref0_lost), .o_ref1_lost(i_ref1_lost));

    // The clock toggles every 2 ns, half of its 4 ns period.
    initial begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk(name, exp, o_rdata);
    endtask

    // Waits out loss reporting plus the one-edge selection latency, then compares.
    task automatic outs(input logic [2:0] exp, input string name);
        repeat (6) @(posedge i_sys_clk);
        #1;
        chk(name, {5'h00, exp}, {5'h00, o_bad_code, o_holdover, o_ref_sel});
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A hang is cut short and counted as a mismatch.
    initial begin
        #100000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        outs(3'b000, "reset outputs");
        rd(`OFS_SELECT, 8'h00, "select reset");
        rd(`OFS_ENABLE, 8'h00, "exclude reset");
        rd(8'hFF, 8'h00, "unmapped read");
        fail1 <= 1'b1;
        wr(`OFS_SELECT, 8'h50);
        outs(3'b001, "force ref1 while lost");
        fail0 <= 1'b1;
        wr(`OFS_SELECT, 8'h40);
        outs(3'b000, "force ref0 while lost");
        rd(`OFS_STATUS, 8'h00, "status word");
        // The two forced switches are logged as {code, new input}, oldest first.
        rd(`OFS_HISTORY, 8'h0B, "history first");
        rd(`OFS_HISTORY, 8'h08, "history second");
        fail0 <= 1'b0;
        fail1 <= 1'b0;
        i_sel_pin <= 1'b1;
        wr(`OFS_SELECT, 8'h10);
        outs(3'b001, "pin high");
        i_sel_pin <= 1'b0;
        outs(3'b000, "pin low");
        wr(`OFS_SELECT, 8'h00);
        outs(3'b000, "auto healthy");
        fail0 <= 1'b1;
        outs(3'b001, "auto switch");
        fail0 <= 1'b0;
        outs(3'b001, "auto stays");
        wr(`OFS_ENABLE, 8'h20);
        outs(3'b000, "ref1 excluded");
        fail0 <= 1'b1;
        outs(3'b010, "no candidate");
        fail0 <= 1'b0;
        wr(`OFS_ENABLE, 8'h10);
        outs(3'b001, "ref0 excluded");
        fail1 <= 1'b1;
        outs(3'b011, "ref0 never picked");
        rd(`OFS_ENABLE, 8'h10, "exclude readback");
        fail1 <= 1'b0;
        wr(`OFS_ENABLE, 8'h00);
        wr(`OFS_SELECT, 8'h50);
        outs(3'b001, "force before bad");
        // Refused codes must hold the present selection.
        foreach (bad_list[k]) begin
            wr(`OFS_SELECT, {1'b0, bad_list[k], 4'h0});
            outs(3'b101, "refused code");
        end
        wr(`OFS_SELECT, 8'h40);
        outs(3'b000, "force after bad");
        conclude();
    end
endmodule
